/* rtl/csram_pkg.sv */
// Purpose: shared constants and types for the clocked static memory host
// Assumes: 20 MHz mclk_in; slowest speed grade timing
// Notes:   times in ns, cycle counts derived by rounding
package csram_pkg;

   // ****************************************
   // clock and array
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int ADDR_W        = 12;
   localparam int TMR_W         = 8;

   // ****************************************
   // times in ns
   // ****************************************
   localparam int STROBE_HIGH_NS        = 500;
   localparam int PRESET_INTERVAL_NS    = 250;
   localparam int ACCESS_DELAY_NS       = 500;
   localparam int WRITE_PULSE_WIDTH_NS  = 200;
   localparam int WRITE_DATA_SETUP_NS   = 200;
   localparam int OUTPUT_OFF_DELAY_NS   = 200;
   localparam int OUTPUT_ON_BEFORE_FALL_NS = 90;

   // least times round up, never below one cycle
   function automatic int csram_cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : csram_cyc_up

   localparam int HIGH_CYC   = csram_cyc_up(STROBE_HIGH_NS);
   localparam int PRESET_CYC = csram_cyc_up(PRESET_INTERVAL_NS);
   localparam int ACCESS_CYC = csram_cyc_up(ACCESS_DELAY_NS);
   localparam int WW_CYC     = csram_cyc_up(WRITE_PULSE_WIDTH_NS);
   localparam int DS_CYC     = csram_cyc_up(WRITE_DATA_SETUP_NS);
   localparam int OFF_CYC    = csram_cyc_up(OUTPUT_OFF_DELAY_NS);
   localparam int ES_CYC     = csram_cyc_up(OUTPUT_ON_BEFORE_FALL_NS);

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_RMW   = 2'h2
   } csram_op_t;

   typedef enum logic [5:0] {
      ST_INIT    = 6'h01,
      ST_IDLE    = 6'h02,
      ST_ACCESS  = 6'h04,
      ST_RMW_OFF = 6'h08,
      ST_RMW_WR  = 6'h10,
      ST_PRESET  = 6'h20
   } csram_state_t;

   typedef struct packed {
      csram_op_t         op;
      logic [ADDR_W-1:0] addr;
      logic              wdata;
   } csram_req_t;

   typedef struct packed {
      logic              strobe;
      logic              chip_sel_n;
      logic              write_n;
      logic              output_on;
      logic              output_off_ctl;
      logic [ADDR_W-1:0] addr;
      logic              wdata;
      logic              wdata_oe;
   } csram_pins_t;

   localparam csram_pins_t PINS_RST = '{
      strobe: 1'h0, chip_sel_n: 1'h1, write_n: 1'h1, output_on: 1'h0,
      output_off_ctl: 1'h1, addr: 12'h000, wdata: 1'h0, wdata_oe: 1'h0};

endpackage : csram_pkg

/* rtl/csram_timer.sv */
// Purpose: down counter pacing each strobe phase
// Assumes: load value is phase length minus one
// Notes:   expired while count is zero
`timescale 1ns/1ps
`default_nettype none
module csram_timer import csram_pkg::*; #(
   parameter int             W         = TMR_W,
   parameter logic [W-1:0]   RESET_CNT = '0
) (
   input  wire logic         mclk_in,     // 20 MHz clock
   input  wire logic         reset_n_in,  // async reset, low
   input  wire logic         clk_en_in,   // freezes count when low
   input  wire logic         load_in,     // load count
   input  wire logic [W-1:0] load_val_in, // cycles minus one
   output logic              expired_out  // count reached zero
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   assign nxt_cnt     = load_in ? load_val_in :
                        (cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;
   assign expired_out = (cnt_ff == '0);

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_ff <= RESET_CNT;
      end else if (clk_en_in) begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule : csram_timer
`default_nettype wire

/* rtl/csram_host.sv */
// Purpose: host that paces a 4096x1 clocked static memory
// Assumes: separate data in/out pins; wdata_oe lets them share a wire
// Notes:   one request at a time; status edges refine min times
`timescale 1ns/1ps
`default_nettype none
module csram_host import csram_pkg::*; #(
   parameter int   HIGH_CYC_P   = HIGH_CYC,
   parameter int   PRESET_CYC_P = PRESET_CYC,
   parameter int   ACCESS_CYC_P = ACCESS_CYC,
   parameter int   WW_CYC_P     = WW_CYC,
   parameter int   OFF_CYC_P    = OFF_CYC,
   parameter logic USE_STATUS   = 1'h1
) (
   input  wire logic        mclk_in,        // 20 MHz clock
   input  wire logic        reset_n_in,     // async reset, low
   input  wire logic        clk_en_in,      // freezes all state when low
   input  wire logic        req_valid_in,   // request offered
   input  wire csram_req_t  req_in,         // op, address, write bit
   output logic             req_ready_out,  // request may be taken
   output logic             resp_valid_out, // one-cycle completion pulse
   output logic             resp_rdata_out, // read bit, held
   output csram_pins_t      pins_out,       // memory pins
   input  wire logic        dout_in,        // memory data output
   input  wire logic        status_in       // memory cycle status
);

   // ****************************************
   // state
   // ****************************************
   csram_state_t state_ff,  nxt_state;
   csram_pins_t  pins_ff,   nxt_pins;
   csram_op_t    op_ff,     nxt_op;
   logic         ready_ff,  nxt_ready;
   logic         rvalid_ff, nxt_rvalid;
   logic         rdata_ff,  nxt_rdata;
   logic         tmr_load;
   logic [TMR_W-1:0] tmr_val;
   logic         tmr_exp;

   function automatic logic csram_reads(input csram_op_t op);
      return (op == OP_READ) || (op == OP_RMW);
   endfunction : csram_reads

   // ****************************************
   // decode
   // ****************************************
   wire take_req = req_valid_in && ready_ff;
   // write from rise: status rise is a valid completion mark
   wire status_hi = status_in || !USE_STATUS;
   wire status_lo = !status_in || !USE_STATUS;
   wire acc_done  = tmr_exp && status_hi;
   wire pre_done  = tmr_exp && status_lo;
   wire [TMR_W-1:0] high_val = TMR_W'(HIGH_CYC_P - 1);
   wire [TMR_W-1:0] acc_val  = TMR_W'(ACCESS_CYC_P - 1);
   wire [TMR_W-1:0] pre_val  = TMR_W'(PRESET_CYC_P - 1);
   wire [TMR_W-1:0] off_val  = TMR_W'(OFF_CYC_P - 1);
   wire [TMR_W-1:0] ww_val   = TMR_W'(WW_CYC_P - 1);

   csram_timer #(
      .W         (TMR_W),
      .RESET_CNT (TMR_W'(PRESET_CYC_P - 1))
   ) u_timer (
      .mclk_in     (mclk_in),
      .reset_n_in  (reset_n_in),
      .clk_en_in   (clk_en_in),
      .load_in     (tmr_load),
      .load_val_in (tmr_val),
      .expired_out (tmr_exp)
   );

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      nxt_state  = state_ff;
      nxt_pins   = pins_ff;
      nxt_op     = op_ff;
      nxt_ready  = ready_ff;
      nxt_rvalid = 1'h0;
      nxt_rdata  = rdata_ff;
      tmr_load   = 1'h0;
      tmr_val    = pre_val;
      case (state_ff)
         // strobe held low from reset until a full preset has run
         ST_INIT: begin
            if (pre_done) begin
               nxt_state = ST_IDLE;
               nxt_ready = 1'h1;
            end
         end
         ST_IDLE: begin
            if (take_req) begin
               nxt_state           = ST_ACCESS;
               nxt_ready           = 1'h0;
               nxt_op              = req_in.op;
               nxt_pins.strobe     = 1'h1;
               nxt_pins.chip_sel_n = 1'h0;
               nxt_pins.addr       = req_in.addr;
               nxt_pins.wdata      = req_in.wdata;
               // plain write: write_n low from rise, data stable
               nxt_pins.write_n    = (req_in.op != OP_WRITE);
               nxt_pins.wdata_oe   = (req_in.op == OP_WRITE);
               // buffer on from rise, well before the fall
               nxt_pins.output_on      = csram_reads(req_in.op);
               nxt_pins.output_off_ctl = !csram_reads(req_in.op);
               tmr_load = 1'h1;
               tmr_val  = (req_in.op == OP_RMW) ? acc_val : high_val;
            end
         end
         ST_ACCESS: begin
            if (acc_done) begin
               if (csram_reads(op_ff)) begin
                  nxt_rdata = dout_in;
               end
               tmr_load = 1'h1;
               if (op_ff == OP_RMW) begin
                  // release the buffer before driving a shared wire
                  nxt_state               = ST_RMW_OFF;
                  nxt_pins.output_on      = 1'h0;
                  nxt_pins.output_off_ctl = 1'h1;
                  tmr_val                 = off_val;
               end else begin
                  nxt_state       = ST_PRESET;
                  nxt_pins.strobe = 1'h0;
                  nxt_rvalid      = 1'h1;
               end
            end
         end
         ST_RMW_OFF: begin
            if (tmr_exp) begin
               nxt_state         = ST_RMW_WR;
               nxt_pins.write_n  = 1'h0;
               nxt_pins.wdata_oe = 1'h1;
               tmr_load          = 1'h1;
               tmr_val           = ww_val;
            end
         end
         // status rise already passed; only the counter ends the write
         ST_RMW_WR: begin
            if (tmr_exp) begin
               nxt_state       = ST_PRESET;
               nxt_pins.strobe = 1'h0;
               nxt_rvalid      = 1'h1;
               tmr_load        = 1'h1;
            end
         end
         ST_PRESET: begin
            // write already ended by the fall; zero hold needed
            nxt_pins.write_n        = 1'h1;
            nxt_pins.wdata_oe       = 1'h0;
            nxt_pins.chip_sel_n     = 1'h1;
            nxt_pins.output_on      = 1'h0;
            nxt_pins.output_off_ctl = 1'h1;
            if (pre_done) begin
               nxt_state = ST_IDLE;
               nxt_ready = 1'h1;
            end
         end
         default: begin
            nxt_state = ST_INIT;
            nxt_pins  = PINS_RST;
            nxt_ready = 1'h0;
            tmr_load  = 1'h1;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff  <= ST_INIT;
         pins_ff   <= PINS_RST;
         op_ff     <= OP_READ;
         ready_ff  <= 1'h0;
         rvalid_ff <= 1'h0;
         rdata_ff  <= 1'h0;
      end else if (clk_en_in) begin
         state_ff  <= nxt_state;
         pins_ff   <= nxt_pins;
         op_ff     <= nxt_op;
         ready_ff  <= nxt_ready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff  <= nxt_rdata;
      end
   end

   assign pins_out       = pins_ff;
   assign req_ready_out  = ready_ff;
   assign resp_valid_out = rvalid_ff;
   assign resp_rdata_out = rdata_ff;

   // ****************************************
   // checks
   // ****************************************
   logic [TMR_W-1:0] hi_cnt_ff, lo_cnt_ff, ovl_cnt_ff;
   logic [TMR_W-1:0] on_cnt_ff, off_cnt_ff, stab_cnt_ff;
   logic             wd_prev_ff;

   function automatic logic [TMR_W-1:0] csram_sat(input logic [TMR_W-1:0] c);
      return (c == '1) ? c : c + TMR_W'(1);
   endfunction : csram_sat

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hi_cnt_ff   <= '0;
         lo_cnt_ff   <= '0;
         ovl_cnt_ff  <= '0;
         on_cnt_ff   <= '0;
         off_cnt_ff  <= '0;
         stab_cnt_ff <= '0;
         wd_prev_ff  <= 1'h0;
      end else if (clk_en_in) begin
         hi_cnt_ff   <= pins_ff.strobe ? csram_sat(hi_cnt_ff) : '0;
         lo_cnt_ff   <= !pins_ff.strobe ? csram_sat(lo_cnt_ff) : '0;
         ovl_cnt_ff  <= (pins_ff.strobe && !pins_ff.write_n) ? csram_sat(ovl_cnt_ff) : '0;
         on_cnt_ff   <= pins_ff.output_on ? csram_sat(on_cnt_ff) : '0;
         off_cnt_ff  <= !pins_ff.output_on ? csram_sat(off_cnt_ff) : '0;
         stab_cnt_ff <= (pins_ff.wdata_oe && pins_ff.wdata == wd_prev_ff) ?
                        csram_sat(stab_cnt_ff) : '0;
         wd_prev_ff  <= pins_ff.wdata;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);

   a_strobe_high_min: assert property (
      $fell(pins_ff.strobe) |-> hi_cnt_ff >= TMR_W'(HIGH_CYC_P))
      else $error("strobe high shorter than minimum");
   a_preset_low_min: assert property (
      $rose(pins_ff.strobe) |-> lo_cnt_ff >= TMR_W'(PRESET_CYC_P))
      else $error("strobe low shorter than preset");
   a_preset_status: assert property (
      $rose(pins_ff.strobe) && USE_STATUS |-> !$past(status_in))
      else $error("strobe rose before status fell");
   a_write_pulse: assert property (
      $fell(pins_ff.strobe) && !$past(pins_ff.write_n) |->
         ovl_cnt_ff >= TMR_W'(WW_CYC_P) && stab_cnt_ff >= TMR_W'(DS_CYC))
      else $error("write overlap or data setup too short");
   a_rmw_high_len: assert property (
      $fell(pins_ff.strobe) && op_ff == OP_RMW |->
         hi_cnt_ff >= TMR_W'(ACCESS_CYC_P + WW_CYC_P))
      else $error("rmw strobe high too short");
   a_rmw_no_status: assert property (
      $fell(pins_ff.strobe) && op_ff == OP_RMW |-> ovl_cnt_ff >= TMR_W'(WW_CYC_P))
      else $error("rmw write ended early");
   a_read_on_early: assert property (
      $fell(pins_ff.strobe) && csram_reads(op_ff) && $past(pins_ff.write_n) |->
         on_cnt_ff >= TMR_W'(ES_CYC))
      else $error("output enabled too late before fall");
   a_drive_after_off: assert property (
      $rose(pins_ff.wdata_oe) |-> !pins_ff.output_on && off_cnt_ff >= TMR_W'(OFF_CYC_P))
      else $error("data driven before output off delay");
   a_write_from_rise: assert property (
      $rose(pins_ff.strobe) && op_ff == OP_WRITE |->
         !pins_ff.write_n && pins_ff.wdata_oe ##1 !pins_ff.write_n)
      else $error("plain write not set up at rise");
   a_init_low: assert property (
      state_ff == ST_INIT |-> !pins_ff.strobe && !ready_ff)
      else $error("strobe raised during power-on preset");
   a_fall_on_status: assert property (
      $fell(pins_ff.strobe) && op_ff != OP_RMW && USE_STATUS |-> $past(status_in))
      else $error("strobe fell before status rose");
   a_resp_with_fall: assert property (
      $fell(pins_ff.strobe) |-> rvalid_ff)
      else $error("completion pulse missing at strobe fall");
   a_take_starts: assert property (
      take_req && clk_en_in |=> pins_ff.strobe && !ready_ff)
      else $error("taken request did not start a cycle");
   a_idle_quiet: assert property (
      state_ff == ST_IDLE |-> !pins_ff.wdata_oe && pins_ff.write_n && !pins_ff.strobe)
      else $error("data driven while idle");

   c_read_done:  cover property (rvalid_ff && op_ff == OP_READ);
   c_write_done: cover property (rvalid_ff && op_ff == OP_WRITE);
   c_rmw_done:   cover property (rvalid_ff && op_ff == OP_RMW);
   c_b2b:        cover property (rvalid_ff ##[1:40] rvalid_ff);
   c_rmw_drive:  cover property ($rose(pins_ff.wdata_oe) && op_ff == OP_RMW);

endmodule : csram_host
`default_nettype wire

/* tb/csram_mem_model.sv */
// Purpose: behavioural 4096x1 clocked static memory for the host bench
// Assumes: pins sampled on mclk_in; access and preset counted in cycles
// Notes:   released data line toggles every cycle, it has no pull
`timescale 1ns/1ps
`default_nettype none
module csram_mem_model import csram_pkg::*; (
   input  wire logic        mclk_in,    // bench clock
   input  wire csram_pins_t pins_in,    // host pins
   input  wire logic        slow_in,    // long access and preset
   output logic             dout_out,   // data, toggles when released
   output logic             status_out  // cycle status, two-state
);
   // ***************************************
   // latches and array
   // ***************************************
   logic              mem [0:4095];
   logic [ADDR_W-1:0] addr_q = '0;
   logic              sel_q = 1'h0;
   logic              q = 1'h0;
   logic              qv = 1'h0;
   logic              tog = 1'h0;
   logic              stb_q = 1'h0;
   logic              stat = 1'h0;
   int                cnt = 0;
   wire               buf_on = pins_in.output_on & ~pins_in.output_off_ctl;
   // stb_q gate: address and select are only valid after the rise edge
   wire               wr = pins_in.strobe & stb_q & ~pins_in.write_n & sel_q;

   assign dout_out = (buf_on & sel_q & qv) ? q : tog;
   assign status_out = stat;

   initial begin
      foreach (mem[i]) mem[i] = 1'h0;
   end

   always @(posedge mclk_in) begin
      tog   <= ~tog;
      stb_q <= pins_in.strobe;
      cnt   <= (pins_in.strobe != stb_q) ? 0 : cnt + 1;
      if (pins_in.strobe & ~stb_q) begin
         addr_q <= pins_in.addr;
         sel_q  <= ~pins_in.chip_sel_n;
         qv     <= 1'h0;
         q      <= 1'h0;
      end
      if (wr) mem[addr_q] <= pins_in.wdata;
      // >= so a speed change mid-cycle cannot hang the status
      if (pins_in.strobe & stb_q & (cnt >= (slow_in ? 14 : 3))) begin
         stat <= 1'h1;
         if (!qv) begin
            q  <= mem[addr_q];
            qv <= 1'h1;
         end
      end
      if (~pins_in.strobe & ~stb_q & (cnt >= (slow_in ? 8 : 2))) stat <= 1'h0;
      if (~pins_in.strobe & ~buf_on) q <= 1'h0;
   end
endmodule : csram_mem_model
`default_nettype wire

/* tb/csram_host_tb_top.sv */
// Purpose: self-checking bench for csram_host against a memory model
// Assumes: default timing parameters, status-paced operation
// Notes:   notes queue pairs each take with its completion pulse
`timescale 1ns/1ps
`default_nettype none
module csram_host_tb_top import csram_pkg::*;;
   localparam int RMW_CYC = (ACCESS_DELAY_NS + WRITE_PULSE_WIDTH_NS) / CLK_PERIOD_NS;
   logic        mclk_in = 1'h0;
   logic        reset_n_in = 1'h0;
   logic        clk_en_in = 1'h1;
   logic        req_valid_in = 1'h0;
   csram_req_t  req_in = '0;
   logic        req_ready_out, resp_valid_out, resp_rdata_out, dout_in, status_in;
   logic        slow = 1'h0;
   csram_pins_t pins_out;
   logic        mirror [0:4095];
   logic [1:0]  notes [$];
   logic [1:0]  nt;
   logic        ps = 1'h0, pov = 1'h0, pd = 1'h0, poe = 1'h0, rd_seen = 1'h0, wr_seen = 1'h0, cen = 1'h0;
   int          bad_count = 0, samples_checked = 0, hi = 0, lo = 0, offc = 0;

   always #(CLK_PERIOD_NS / 2) mclk_in = ~mclk_in;

   csram_host csram_host_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
      .resp_valid_out(resp_valid_out), .resp_rdata_out(resp_rdata_out), .pins_out(pins_out),
      .dout_in(dout_in), .status_in(status_in));
   csram_mem_model csram_mem_model_i (.mclk_in(mclk_in), .pins_in(pins_out), .slow_in(slow),
      .dout_out(dout_in), .status_out(status_in));

   // ***************************************
   // checking and ending
   // ***************************************
   task automatic chk(input string nm, input logic e, input logic s);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", nm, e, s);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // watches completions and the pin timing of every cycle
   always @(posedge mclk_in) begin
      cen = clk_en_in;
      #2;
      if (reset_n_in !== 1'h1) begin
         hi = 0;
         lo = 0;
         ps = 1'h0;
         pov = 1'h0;
         poe = 1'h0;
      end else begin
         // a frozen clock enable holds the pulse; count it once
         if (resp_valid_out === 1'h1 && cen === 1'h1) begin
            if (notes.size() == 0) chk("resp_extra", 1'h0, 1'h1);
            else begin
               nt = notes.pop_front();
               if (nt[1]) chk("rdata", nt[0], resp_rdata_out);
            end
         end
         if (pins_out.strobe & ~ps) begin
            chk("low_time", 1'h1, lo >= PRESET_CYC);
            chk("status_at_rise", 1'h0, status_in);
         end
         if (~pins_out.strobe & ps) begin
            chk("high_time", 1'h1, hi >= ((rd_seen & wr_seen) ? RMW_CYC : HIGH_CYC));
            chk("status_at_fall", 1'h1, status_in);
         end
         if (pins_out.strobe & ~pins_out.write_n & pov) chk("wdata_hold", pd, pins_out.wdata);
         if (pins_out.wdata_oe & ~poe) chk("oe_gap", 1'h1, offc >= OFF_CYC);
         if (pins_out.strobe) chk("ready_busy", 1'h0, req_ready_out);
         hi = pins_out.strobe ? hi + 1 : 0;
         lo = pins_out.strobe ? 0 : lo + 1;
         ps = pins_out.strobe;
         pov = pins_out.strobe & ~pins_out.write_n;
         pd = pins_out.wdata;
         poe = pins_out.wdata_oe;
      end
      offc = (pins_out.output_on & ~pins_out.output_off_ctl) ? 0 : offc + 1;
      rd_seen = pins_out.strobe & (rd_seen | pins_out.output_on);
      wr_seen = pins_out.strobe & (wr_seen | ~pins_out.write_n);
   end

   // ***************************************
   // stimulus
   // ***************************************
   // offers one request; clock enable flickers while it waits
   task automatic do_op(input csram_op_t op, input logic [ADDR_W-1:0] a, input logic d);
      int n;
      n = 0;
      @(posedge mclk_in);
      #1;
      req_in = '{op: op, addr: a, wdata: d};
      req_valid_in = 1'h1;
      while (!(req_ready_out === 1'h1 && clk_en_in === 1'h1) && n < 400) begin
         @(posedge mclk_in);
         #1;
         clk_en_in = ($urandom_range(7) != 0);
         n++;
      end
      if (n >= 400) chk("ready_wait", 1'h1, 1'h0);
      notes.push_back({op != OP_WRITE, mirror[a]});
      if (op != OP_READ) mirror[a] = d;
      @(posedge mclk_in);
      #1;
      req_valid_in = 1'h0;
      clk_en_in = 1'h1;
   endtask : do_op

   initial begin
      int i;
      logic [ADDR_W-1:0] a;
      csram_op_t op;
      void'($urandom(66463));
      foreach (mirror[k]) mirror[k] = 1'h0;
      repeat (4) @(posedge mclk_in);
      #1;
      reset_n_in = 1'h1;
      for (i = 0; i < 30; i++) begin
         slow = 1'($urandom_range(1));
         op = csram_op_t'((i < 6) ? i % 3 : $urandom_range(2));
         a = 12'($urandom_range(3));
         if (i[0]) a = ~a;
         do_op(op, a, 1'($urandom_range(1)));
      end
      // reset in mid-cycle, then the host must start over cleanly
      do_op(OP_READ, 12'h000, 1'h0);
      repeat (3) @(posedge mclk_in);
      #1;
      reset_n_in = 1'h0;
      void'(notes.pop_back());
      repeat (2) @(posedge mclk_in);
      #1;
      reset_n_in = 1'h1;
      do_op(OP_WRITE, 12'hFFF, 1'h1);
      do_op(OP_READ, 12'hFFF, 1'h0);
      do_op(OP_RMW, 12'hFFF, 1'h0);
      do_op(OP_READ, 12'hFFF, 1'h0);
      for (i = 0; i < 100 && notes.size() > 0; i++) @(posedge mclk_in);
      chk("notes_left", 1'h0, notes.size() != 0);
      complete_run();
   end

   initial begin
      #(CLK_PERIOD_NS * 6000);
      bad_count++;
      complete_run();
   end
endmodule : csram_host_tb_top
`default_nettype wire
